// >>> core/ctbd_top.sv
// charge termination, battery detect and timer control with axi4-lite registers
`timescale 1ns/1ps
module ctbd_top
#(
   parameter longint precharge_limit  = ctbd_pkg::precharge_cycles,
   parameter longint fastcharge_limit = ctbd_pkg::fastcharge_cycles,
   parameter longint boost_limit      = ctbd_pkg::boost_cycles
)
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   // comparator and pin inputs
   input  wire logic        vout_above_rch,
   input  wire logic        iout_below_term,
   input  wire logic        iout_below_term_boost,
   input  wire logic        temp_sense_input,
   input  wire logic        temp_fault,
   input  wire logic        bat_low_precharge,
   input  wire logic        bat_cmp,
   input  wire logic        thermal_reg,
   input  wire logic        input_voltage_power_mgmt,
   input  wire logic        usb_limit,
   // analog controls, status pin and interrupt
   output logic             charge_en,
   output logic             probe_en,
   output logic             term_boost,
   output logic             charge_status_n_o,
   output logic             charge_status_n_oe,
   output logic             irq,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   ////////////////////////////////////////////////////////////////////////////////
   // reset release and input synchronisers
   logic [1:0] rs_r;
   logic       rst_n;
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         rs_r <= 2'b00;
      else
         rs_r <= {rs_r[0], 1'b1};
   end
   assign rst_n = rs_r[1];

   localparam int ni = 10;
   logic [ni-1:0] in_raw, s1_r, s2_r;
   assign in_raw = {vout_above_rch, iout_below_term, iout_below_term_boost, temp_sense_input,
                    temp_fault, bat_low_precharge, bat_cmp, thermal_reg,
                    input_voltage_power_mgmt, usb_limit};
   // no reset: the stages fill while reset is held, so idle sees real levels at release
   always_ff @(posedge clock)
   begin
      s1_r <= in_raw;
      s2_r <= s1_r;
   end
   logic v_rch, i_term, i_term_b, ts_high, ts_fault, bat_low, b_cmp, slow;
   assign {v_rch, i_term, i_term_b, ts_high, ts_fault, bat_low, b_cmp} = s2_r[9:3];
   assign slow = |s2_r[2:0];

   ////////////////////////////////////////////////////////////////////////////////
   // detect sub-sequence
   logic det_start, det_done, det_present;
   ctbd_detect u_det
   (
      .clock   (clock),
      .rst_n   (rst_n),
      .start   (det_start),
      .done    (det_done),
      .present (det_present),
      .probe_en(probe_en),
      .bat_cmp (b_cmp)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // main charge state machine
   ctbd_pkg::ctbd_state_type st_r, st_nxt;
   logic        pend_r, pend_nxt;       // detect running
   logic        refresh_r, refresh_nxt; // current cycle is a refresh
   logic        status_r, status_nxt;   // status pin pulled low
   logic        term_timer_disable_mode_exit_r, term_timer_disable_mode_exit_nxt;
   logic [40:0] tmr_r, tmr_nxt;
   logic        half_r, half_nxt;
   logic [31:0] boost_r, boost_nxt;
   logic [ctbd_pkg::ev_count-1:0] ev;
   logic        sw_enable, start_cyc, taper, expired;

   // termination uses the raised threshold during the first minute
   assign term_boost = (boost_r != 32'h0);
   assign taper = v_rch && (term_boost ? i_term_b : i_term);
   assign expired = bat_low ? (tmr_r >= 41'(precharge_limit))
                            : (tmr_r >= 41'(fastcharge_limit));

   always_comb
   begin
      st_nxt        = st_r;
      pend_nxt      = pend_r;
      refresh_nxt   = refresh_r;
      status_nxt    = status_r;
      term_timer_disable_mode_exit_nxt = term_timer_disable_mode_exit_r;
      tmr_nxt       = tmr_r;
      half_nxt      = half_r;
      boost_nxt     = (boost_r != 32'h0) ? boost_r - 32'h1 : 32'h0;
      det_start     = 1'b0;
      start_cyc     = 1'b0;
      ev            = '0;
      if (st_r == ctbd_pkg::st_charge)
      begin
         // slowed modes advance the fast timer every other cycle
         half_nxt = slow ? ~half_r : 1'b0;
         if (!slow || half_r || bat_low)
            tmr_nxt = tmr_r + 41'h1;
      end
      case (st_r)
         ctbd_pkg::st_idle:
         begin
            if (sw_enable && v_rch)
            begin
               st_nxt = ctbd_pkg::st_detect;
               det_start = !ts_fault;
            end
            else if (sw_enable)
               start_cyc = 1'b1;
         end
         ctbd_pkg::st_detect:
         begin
            status_nxt = 1'b0;
            if (ts_high)
            begin
               st_nxt = ctbd_pkg::st_term_timer_disable_mode;
               ev[ctbd_pkg::ev_term_timer_disable_mode_in] = 1'b1;
            end
            else if (ts_fault)
               st_nxt = ctbd_pkg::st_fault;
            else if (!pend_r)
            begin
               det_start = 1'b1;
               pend_nxt  = 1'b1;
            end
            else if (det_done)
            begin
               pend_nxt = 1'b0;
               if (det_present && (term_timer_disable_mode_exit_r || !refresh_r))
               begin
                  start_cyc = 1'b1;
                  term_timer_disable_mode_exit_nxt = 1'b0;
               end
               else if (det_present)
               begin
                  st_nxt = ctbd_pkg::st_term;
                  ev[ctbd_pkg::ev_terminated] = 1'b1;
               end
               else
               begin
                  // a battery put in later starts a fresh cycle, not a refresh
                  ev[ctbd_pkg::ev_absent] = 1'b1;
                  refresh_nxt = 1'b0;
               end
            end
         end
         ctbd_pkg::st_charge:
         begin
            if (ts_high)
            begin
               st_nxt = ctbd_pkg::st_term_timer_disable_mode;
               ev[ctbd_pkg::ev_term_timer_disable_mode_in] = 1'b1;
            end
            else if (ts_fault)
               st_nxt = ctbd_pkg::st_fault;
            else if (expired)
            begin
               st_nxt = ctbd_pkg::st_term;
               status_nxt = 1'b0;
               ev[ctbd_pkg::ev_timeout] = 1'b1;
            end
            else if (taper)
            begin
               st_nxt = ctbd_pkg::st_detect;
               status_nxt = 1'b0;
               refresh_nxt = 1'b1;
            end
         end
         ctbd_pkg::st_term:
         begin
            if (ts_high)
            begin
               st_nxt = ctbd_pkg::st_term_timer_disable_mode;
               ev[ctbd_pkg::ev_term_timer_disable_mode_in] = 1'b1;
            end
            else if (!v_rch)
            begin
               st_nxt = ctbd_pkg::st_charge;
               refresh_nxt = 1'b1;
               tmr_nxt = '0;
               boost_nxt = 32'(boost_limit);
               ev[ctbd_pkg::ev_refresh] = 1'b1;
            end
         end
         ctbd_pkg::st_term_timer_disable_mode:
         begin
            // charging continues without termination, timer cleared
            tmr_nxt = '0;
            if (!ts_high)
            begin
               st_nxt = ctbd_pkg::st_detect;
               term_timer_disable_mode_exit_nxt = 1'b1;
               pend_nxt = 1'b0;
            end
         end
         ctbd_pkg::st_fault:
         begin
            if (!ts_fault)
            begin
               st_nxt = ctbd_pkg::st_detect;
               pend_nxt = 1'b0;
               refresh_nxt = 1'b0;
            end
         end
         default: st_nxt = ctbd_pkg::st_idle;
      endcase
      if (start_cyc)
      begin
         st_nxt = ctbd_pkg::st_charge;
         status_nxt = 1'b1;
         refresh_nxt = 1'b0;
         tmr_nxt = '0;
         half_nxt = 1'b0;
         boost_nxt = 32'(boost_limit);
      end
      if (!sw_enable)
      begin
         st_nxt = ctbd_pkg::st_idle;
         status_nxt = 1'b0;
         pend_nxt = 1'b0;
         refresh_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r        <= ctbd_pkg::st_idle;
         pend_r      <= 1'b0;
         refresh_r   <= 1'b0;
         status_r    <= 1'b0;
         term_timer_disable_mode_exit_r <= 1'b0;
         tmr_r       <= '0;
         half_r      <= 1'b0;
         boost_r     <= 32'h0;
      end
      else
      begin
         st_r        <= st_nxt;
         pend_r      <= pend_nxt;
         refresh_r   <= refresh_nxt;
         status_r    <= status_nxt;
         term_timer_disable_mode_exit_r <= term_timer_disable_mode_exit_nxt;
         tmr_r       <= tmr_nxt;
         half_r      <= half_nxt;
         boost_r     <= boost_nxt;
      end
   end

   assign charge_en = (st_r == ctbd_pkg::st_charge) || (st_r == ctbd_pkg::st_term_timer_disable_mode);
   assign charge_status_n_o  = 1'b0;
   assign charge_status_n_oe = status_r;

   ////////////////////////////////////////////////////////////////////////////////
   // registers: ctrl bit0 enable, status, sticky events, mask
   logic [31:0] ctrl_r, ctrl_nxt;
   logic [4:0]  irq_r, irq_nxt, mask_r, mask_nxt;
   logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        wr_go, rd_go;
   assign sw_enable = ctrl_r[0];
   // write waits for both channels so they may come in either order
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
   assign rd_go = s_axi_arvalid && !rvalid_r;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;

   always_comb
   begin
      ctrl_nxt   = ctrl_r;
      mask_nxt   = mask_r;
      irq_nxt    = irq_r;
      bvalid_nxt = bvalid_r && !s_axi_bready;
      bresp_nxt  = bresp_r;
      rvalid_nxt = rvalid_r && !s_axi_rready;
      rresp_nxt  = rresp_r;
      rdata_nxt  = rdata_r;
      if (wr_go)
      begin
         bvalid_nxt = 1'b1;
         bresp_nxt  = 2'b00;
         case (s_axi_awaddr)
            ctbd_pkg::reg_ctrl_off: if (s_axi_wstrb[0]) ctrl_nxt = {31'h0, s_axi_wdata[0]};
            ctbd_pkg::reg_irq_off:  if (s_axi_wstrb[0]) irq_nxt = irq_r & ~s_axi_wdata[4:0];
            ctbd_pkg::reg_mask_off: if (s_axi_wstrb[0]) mask_nxt = s_axi_wdata[4:0];
            ctbd_pkg::reg_status_off: bresp_nxt = 2'b00;
            default: bresp_nxt = 2'b10;
         endcase
      end
      // set wins over a clear in the same cycle
      irq_nxt = irq_nxt | ev;
      if (rd_go)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = 2'b00;
         case (s_axi_araddr)
            ctbd_pkg::reg_ctrl_off:   rdata_nxt = ctrl_r;
            ctbd_pkg::reg_status_off: rdata_nxt = {24'h0, charge_en, status_r,
                                                  1'b0, pend_r, 1'b0, st_r};
            ctbd_pkg::reg_irq_off:    rdata_nxt = {27'h0, irq_r};
            ctbd_pkg::reg_mask_off:   rdata_nxt = {27'h0, mask_r};
            default:
            begin
               rdata_nxt = 32'h0;
               rresp_nxt = 2'b10;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r   <= ctbd_pkg::ctrl_reset;
         mask_r   <= ctbd_pkg::mask_reset;
         irq_r    <= 5'h00;
         bvalid_r <= 1'b0;
         bresp_r  <= 2'b00;
         rvalid_r <= 1'b0;
         rresp_r  <= 2'b00;
         rdata_r  <= 32'h0;
      end
      else
      begin
         ctrl_r   <= ctrl_nxt;
         mask_r   <= mask_nxt;
         irq_r    <= irq_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r  <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r  <= rresp_nxt;
         rdata_r  <= rdata_nxt;
      end
   end
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp  = rresp_r;
   assign s_axi_rdata  = rdata_r;
   assign irq = |(irq_r & mask_r);

   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   property p_taper_release;
      @(posedge clock) disable iff (!rst_n)
      (st_r == ctbd_pkg::st_charge && sw_enable && !ts_high && !ts_fault && !expired && taper)
      |=> (!charge_status_n_oe && st_r == ctbd_pkg::st_detect);
   endproperty
   a_taper_release: assert property (p_taper_release) else $error("taper no release");
   property p_term_no_charge;
      @(posedge clock) disable iff (!rst_n)
      (st_r == ctbd_pkg::st_term) |-> !charge_en;
   endproperty
   a_term_no_charge: assert property (p_term_no_charge) else $error("charge in term");
   property p_ts_term_timer_disable_mode;
      @(posedge clock) disable iff (!rst_n)
      (st_r == ctbd_pkg::st_charge && ts_high && sw_enable) |=> (st_r == ctbd_pkg::st_term_timer_disable_mode);
   endproperty
   a_ts_term_timer_disable_mode: assert property (p_ts_term_timer_disable_mode) else $error("no term_timer_disable_mode entry");
   property p_absent_released;
      @(posedge clock) disable iff (!rst_n)
      (st_r == ctbd_pkg::st_detect) |-> !charge_status_n_oe;
   endproperty
   a_absent_released: assert property (p_absent_released) else $error("pin low in detect");
   property p_no_probe_term_timer_disable_mode;
      @(posedge clock) disable iff (!rst_n)
      (st_r == ctbd_pkg::st_term_timer_disable_mode) |-> !det_start;
   endproperty
   a_no_probe_term_timer_disable_mode: assert property (p_no_probe_term_timer_disable_mode) else $error("detect in term_timer_disable_mode");
   property p_term_timer_disable_mode_timer;
      @(posedge clock) disable iff (!rst_n)
      (st_r == ctbd_pkg::st_term_timer_disable_mode) |=> (tmr_r == 41'h0);
   endproperty
   a_term_timer_disable_mode_timer: assert property (p_term_timer_disable_mode_timer) else $error("timer runs in term_timer_disable_mode");
   property p_refresh_pin;
      @(posedge clock) disable iff (!rst_n)
      (st_r == ctbd_pkg::st_term && !v_rch && !ts_high && sw_enable)
      |=> (st_r == ctbd_pkg::st_charge && !charge_status_n_oe);
   endproperty
   a_refresh_pin: assert property (p_refresh_pin) else $error("refresh wrong");
   property p_boost_start;
      @(posedge clock) disable iff (!rst_n)
      start_cyc |=> ##1 term_boost;
   endproperty
   a_boost_start: assert property (p_boost_start) else $error("no boost");
   property p_probe_result;
      @(posedge clock) disable iff (!rst_n)
      det_start |-> ##[1:80] det_done;
   endproperty
   a_probe_result: assert property (p_probe_result) else $error("detect hung");
endmodule : ctbd_top

// >>> core/ctbd_pkg.sv
// package of constants for the charge termination and battery detect block
package ctbd_pkg;
   // clock rate
   localparam longint clk_hz              = 40000000;
   // times in their own units
   localparam longint precharge_time_min  = 30;
   localparam longint fastcharge_time_hr  = 10;
   localparam longint boost_time_min      = 1;
   // counts of cycles derived from the rate
   localparam longint precharge_cycles    = precharge_time_min * 60 * clk_hz;
   localparam longint fastcharge_cycles   = fastcharge_time_hr * 3600 * clk_hz;
   localparam longint boost_cycles        = boost_time_min * 60 * clk_hz;
   // battery detect probe timing
   localparam int     probe_settle_cycles = 64;
   localparam logic [7:0] probe_settle_init = 8'h40;
   // register map
   localparam logic [7:0] reg_ctrl_off    = 8'h00;
   localparam logic [7:0] reg_status_off  = 8'h04;
   localparam logic [7:0] reg_irq_off     = 8'h08;
   localparam logic [7:0] reg_mask_off    = 8'h0c;
   // reset values
   localparam logic [31:0] ctrl_reset     = 32'h0000_0001;
   localparam logic [4:0]  mask_reset     = 5'h00;
   // event bit positions
   localparam int ev_terminated = 0;
   localparam int ev_timeout    = 1;
   localparam int ev_absent     = 2;
   localparam int ev_term_timer_disable_mode_in    = 3;
   localparam int ev_refresh    = 4;
   localparam int ev_count      = 5;
   // charge states
   typedef enum logic [2:0]
   {
      st_idle   = 3'b000,
      st_detect = 3'b001,
      st_charge = 3'b010,
      st_term   = 3'b011,
      st_term_timer_disable_mode   = 3'b100,
      st_fault  = 3'b101
   } ctbd_state_type;
   // detect sub-states
   typedef enum logic [1:0]
   {
      dt_idle   = 2'b00,
      dt_probe  = 2'b01,
      dt_sample = 2'b10,
      dt_done   = 2'b11
   } ctbd_det_type;
endpackage : ctbd_pkg

// >>> core/ctbd_detect.sv
// battery detect probe sequencer
`timescale 1ns/1ps
module ctbd_detect
(
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // request and answer
   input  wire logic start,
   output logic      done,
   output logic      present,
   // analog probe
   output logic      probe_en,
   input  wire logic bat_cmp
);
   ctbd_pkg::ctbd_det_type st_r, st_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic       pres_r, pres_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // probe drives, waits for settling, then samples the comparator
   always_comb
   begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      pres_nxt = pres_r;
      case (st_r)
         ctbd_pkg::dt_idle:
         begin
            if (start)
            begin
               st_nxt  = ctbd_pkg::dt_probe;
               cnt_nxt = ctbd_pkg::probe_settle_init;
            end
         end
         ctbd_pkg::dt_probe:
         begin
            if (cnt_r == 8'h00)
               st_nxt = ctbd_pkg::dt_sample;
            else
               cnt_nxt = cnt_r - 8'h01;
         end
         ctbd_pkg::dt_sample:
         begin
            pres_nxt = bat_cmp;
            st_nxt   = ctbd_pkg::dt_done;
         end
         ctbd_pkg::dt_done:  st_nxt = ctbd_pkg::dt_idle;
         default:            st_nxt = ctbd_pkg::dt_idle;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r   <= ctbd_pkg::dt_idle;
         cnt_r  <= 8'h00;
         pres_r <= 1'b0;
      end
      else
      begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         pres_r <= pres_nxt;
      end
   end

   // probe sources only a small current so the output stays usable
   assign probe_en = (st_r == ctbd_pkg::dt_probe) || (st_r == ctbd_pkg::dt_sample);
   assign done     = (st_r == ctbd_pkg::dt_done);
   assign present  = pres_r;
endmodule : ctbd_detect

// >>> verif/ctbd_pack.sv
// battery pack, thermistor and status line model
`timescale 1ns/1ps
module ctbd_pack
(
   // scenario controls
   input  wire logic present,
   input  wire logic ts_hold,
   input  wire logic full,
   input  wire logic taper,
   // from the block
   input  wire logic charge_en,
   input  wire logic pin_oe,
   // to the block, plus the status line level to the bench
   output logic      bat_cmp,
   output logic      temp_sense,
   output logic      vout_hi,
   output logic      iout_lo,
   output logic      pin
);
////////////////////////////////////////////////////////////////////////
   // thermistor leaves with the pack unless the host holds the line
   assign temp_sense = !present && !ts_hold;
   assign bat_cmp    = present;
   // an unloaded output rises whenever charge current flows
   assign vout_hi    = present ? full : charge_en;
   assign iout_lo    = taper || !present;
   // pull-up on the open-drain status line
   assign pin        = pin_oe ? 1'b0 : 1'b1;
endmodule : ctbd_pack

// >>> verif/ctbd_top_tb_top.sv
// self-checking bench for the charge control block
`timescale 1ns/1ps
module ctbd_top_tb_top;
////////////////////////////////////////////////////////////////////////
   logic        clock, reset_n, present, ts_hold, full, taper, bat_low, ts_flt, slow_in;
   logic        bat_cmp, temp_sense_input, vout_above_rch, iout_lo;
   logic        charge_en, probe_en, term_boost, pin_o, pin_oe, pin, irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          err_count, samples_checked, n;
////////////////////////////////////////////////////////////////////////
   ctbd_top #(.precharge_limit(200), .fastcharge_limit(400), .boost_limit(50)) dut
   (
      .clock, .reset_n, .vout_above_rch, .iout_below_term(iout_lo),
      .iout_below_term_boost(iout_lo), .temp_sense_input, .temp_fault(ts_flt),
      .bat_low_precharge(bat_low), .bat_cmp, .thermal_reg(slow_in),
      .input_voltage_power_mgmt(1'b0), .usb_limit(1'b0), .charge_en, .probe_en,
      .term_boost, .charge_status_n_o(pin_o), .charge_status_n_oe(pin_oe), .irq,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready
   );
   ctbd_pack pack
   (
      .present, .ts_hold, .full, .taper, .charge_en, .pin_oe, .bat_cmp,
      .temp_sense(temp_sense_input), .vout_hi(vout_above_rch), .iout_lo, .pin
   );
////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         err_count++;
         $display("CHECK FAILED %0t: saw %h want %h", $time, seen, want);
      end
   endtask : chk
   // changes land by nba just after a rising edge; ready and answers are taken at that edge
   // the leading edge keeps two calls in a row from driving one signal twice in a step
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do @(posedge clock); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      do @(posedge clock); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready  <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge clock); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clock); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready  <= 1'b0;
   endtask : rd
   task automatic poll(input logic [2:0] s);
      n = 0;
      do
      begin
         rd(ctbd_pkg::reg_status_off);
         n++;
      end
      while (d[2:0] !== s && n < 200);
      chk(d[2:0], s);
   endtask : poll
   // pin level, charge current, raised threshold, interrupt
   task automatic look(input logic [3:0] want);
      @(negedge clock);
      chk({pin, charge_en, term_boost, irq}, want);
      @(posedge clock);
   endtask : look
   task automatic events(input logic [4:0] want);
      rd(ctbd_pkg::reg_irq_off);
      chk(d[4:0], want);
      wr(ctbd_pkg::reg_irq_off, 32'h0000_001f);
   endtask : events
   task automatic probe_cnt(input int cyc);
      n = 0;
      repeat (cyc)
      begin
         @(negedge clock);
         n += int'(probe_en === 1'b1);
      end
      @(posedge clock);
   endtask : probe_cnt
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // whole run is a few thousand cycles
   initial
   begin
      #(25 * 40000);
      err_count++;
      give_verdict();
   end
   initial
   begin
      {reset_n, ts_hold, full, taper, bat_low, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, ts_flt, slow_in} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      present = 1'b1;
      err_count = 0;
      samples_checked = 0;
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      repeat (3) @(posedge clock);
      rd(ctbd_pkg::reg_ctrl_off);
      chk(d, ctbd_pkg::ctrl_reset);
      rd(ctbd_pkg::reg_mask_off);
      chk(d[4:0], ctbd_pkg::mask_reset);
      rd(8'h10);
      chk(r, 2'b10);
      wr(8'h10, 32'h0000_0001);
      chk(r, 2'b10);
      $display("test registers done");
      poll(ctbd_pkg::st_charge);
      look(4'b0110);
      repeat (60) @(posedge clock);
      look(4'b0100);
      wr(ctbd_pkg::reg_ctrl_off, 32'h0000_0000);
      full <= 1'b1;
      poll(ctbd_pkg::st_idle);
      wr(ctbd_pkg::reg_ctrl_off, 32'h0000_0001);
      poll(ctbd_pkg::st_detect);
      poll(ctbd_pkg::st_charge);
      look(4'b0110);
      $display("test fresh cycle done");
      full <= 1'b1;
      taper <= 1'b1;
      poll(ctbd_pkg::st_term);
      look(4'b1000);
      wr(ctbd_pkg::reg_mask_off, 32'h0000_001f);
      look(4'b1001);
      events(5'h01);
      look(4'b1000);
      $display("test taper and interrupt done");
      full <= 1'b0;
      taper <= 1'b0;
      poll(ctbd_pkg::st_charge);
      look(4'b1111);
      events(5'h10);
      $display("test refresh done");
      full <= 1'b1;
      slow_in <= 1'b1;
      repeat (600) @(posedge clock);
      rd(ctbd_pkg::reg_status_off);
      chk(d[2:0], ctbd_pkg::st_charge);
      poll(ctbd_pkg::st_term);
      slow_in <= 1'b0;
      look(4'b1001);
      events(5'h02);
      $display("test timeout done");
      present <= 1'b0;
      poll(ctbd_pkg::st_term_timer_disable_mode);
      @(negedge clock);
      chk({pin, charge_en}, 2'b11);
      @(posedge clock);
      probe_cnt(150);
      chk(n, 0);
      events(5'h08);
      full <= 1'b0;
      taper <= 1'b0;
      present <= 1'b1;
      poll(ctbd_pkg::st_charge);
      look(4'b0110);
      $display("test term_timer_disable_mode done");
      ts_hold <= 1'b1;
      present <= 1'b0;
      poll(ctbd_pkg::st_detect);
      probe_cnt(300);
      chk(n > 100, 1'b1);
      @(negedge clock);
      chk(pin, 1'b1);
      @(posedge clock);
      rd(ctbd_pkg::reg_irq_off);
      chk(d[ctbd_pkg::ev_absent], 1'b1);
      ts_flt <= 1'b1;
      poll(ctbd_pkg::st_fault);
      // a pass already under way finishes before the probe goes quiet
      repeat (80) @(posedge clock);
      probe_cnt(100);
      chk(n, 0);
      ts_flt <= 1'b0;
      ts_hold <= 1'b0;
      present <= 1'b1;
      poll(ctbd_pkg::st_charge);
      look(4'b0111);
      $display("test absent pack done");
      give_verdict();
   end
endmodule : ctbd_top_tb_top
